/* hw/tcc_top.sv */
// Purpose: 16-bit up-counter with two compares, two captures and two toggles.
// Assumes: Register strobes are one cycle long and never overlap.
// Notes:   Read data appear in the cycle after the read strobe only.
`timescale 1ns/100ps

module tcc_top import tcc_pkg::*; (
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [DW-1:0] reg_rdata,
    input  wire logic          event_in_a,
    input  wire logic          event_in_b,
    input  wire logic          ext_gate_toggle,
    output logic               wave_out_a,
    output logic               wave_out_b,
    output logic               match_pulse_a,
    output logic               match_pulse_b,
    output logic               irq
);
    logic [MODE_W-1:0] timer_mode_reg;
    logic [5:2]        toggle_ctrl_reg;
    logic [DW-1:0]     compare_reg_a;
    logic [DW-1:0]     compare_reg_b;
    logic [DW-1:0]     capture_reg_1;
    logic [DW-1:0]     capture_reg_2;
    logic [DW-1:0]     up_counter;
    logic [ST_W-1:0]   status_reg;
    logic [ST_W-1:0]   irq_en_reg;
    logic              out_toggle_a;
    logic              out_toggle_b;
    logic [DW-1:0]     rdata_reg;
    logic              irq_reg;
    logic              match_a_reg;
    logic              match_b_reg;

    logic              tap1;
    logic              tap4;
    logic              tap16;
    logic              a_rise;
    logic              a_fall;
    logic              b_rise;
    logic              b_fall;
    logic              g_rise;
    logic              g_fall;
    logic              tick;
    logic              hit_a;
    logic              hit_b;
    logic              capture_reg_1_load;
    logic              capture_reg_2_load;
    logic              inv_a;
    logic              inv_b;
    logic [ST_W-1:0]   events;
    logic [DW-1:0]     rd_mux;
    tcc_clk_sel_type   clk_sel;
    tcc_cap_mode_type  capture_mode_sel;
    logic              run;
    logic              clr_en;
    logic              wr_mode;
    logic              wr_tctl;
    logic              wr_cmp_a;
    logic              wr_cmp_b;
    logic              wr_clr;
    logic              wr_en;

    // Next toggle value: a software invert, clear or set code wins over a hardware inversion.
    function automatic logic tgl_next(input logic cur, input logic sw,
                                      input logic [1:0] code, input logic hw);
        logic nxt;
        nxt = cur ^ hw;
        if (sw)
        begin
            if (code == TGL_INVERT)
                nxt = ~cur;
            else if (code == TGL_CLEAR)
                nxt = 1'b0;
            else if (code == TGL_SET)
                nxt = 1'b1;
        end
        return nxt;
    endfunction

    // Mode fields.
    assign clk_sel          = tcc_clk_sel_type'(timer_mode_reg[MODE_CLK_LSB +: 2]);
    assign capture_mode_sel = tcc_cap_mode_type'(timer_mode_reg[MODE_CAP_LSB +: 2]);
    assign run              = timer_mode_reg[MODE_RUN];
    assign clr_en           = timer_mode_reg[MODE_CLR_EN];

    // Write decode.
    always_comb
    begin
        wr_mode  = 1'b0;
        wr_tctl  = 1'b0;
        wr_cmp_a = 1'b0;
        wr_cmp_b = 1'b0;
        wr_clr   = 1'b0;
        wr_en    = 1'b0;
        if (!reg_wr)
            wr_mode = 1'b0;
        else if (reg_addr == ADDR_MODE)
            wr_mode = 1'b1;
        else if (reg_addr == ADDR_TCTL)
            wr_tctl = 1'b1;
        else if (reg_addr == ADDR_CMP_A)
            wr_cmp_a = 1'b1;
        else if (reg_addr == ADDR_CMP_B)
            wr_cmp_b = 1'b1;
        else if (reg_addr == ADDR_IRQ_CLR)
            wr_clr = 1'b1;
        else if (reg_addr == ADDR_IRQ_EN)
            wr_en = 1'b1;
    end

    // Prescaler taps for the internal count clock.
    tcc_prescaler u_pre (
        .mclk  (mclk),
        .reset (reset),
        .run   (run),
        .tap1  (tap1),
        .tap4  (tap4),
        .tap16 (tap16)
    );

    // Pins are synchronised before any edge is used.
    tcc_edge_sync u_sync_a (
        .mclk  (mclk),
        .reset (reset),
        .pin   (event_in_a),
        .rise  (a_rise),
        .fall  (a_fall)
    );
    tcc_edge_sync u_sync_b (
        .mclk  (mclk),
        .reset (reset),
        .pin   (event_in_b),
        .rise  (b_rise),
        .fall  (b_fall)
    );
    tcc_edge_sync u_sync_g (
        .mclk  (mclk),
        .reset (reset),
        .pin   (ext_gate_toggle),
        .rise  (g_rise),
        .fall  (g_fall)
    );

    // Count enable from the selected source.
    always_comb
    begin
        case (clk_sel)
            TCC_CLK_EVENT_A: tick = run && a_rise;
            TCC_CLK_TAP1:    tick = tap1;
            TCC_CLK_TAP4:    tick = tap4;
            default:         tick = tap16;
        endcase
    end

    // Matches are taken on the count edge so each gives one pulse.
    assign hit_a = tick && up_counter == compare_reg_a;
    assign hit_b = tick && up_counter == compare_reg_b;

    // Capture strobes by mode.
    always_comb
    begin
        capture_reg_1_load = 1'b0;
        capture_reg_2_load = 1'b0;
        case (capture_mode_sel)
            TCC_CAP_TDIFF:
            begin
                capture_reg_1_load = a_rise;
                capture_reg_2_load = b_rise;
            end
            TCC_CAP_PWIDTH:
            begin
                capture_reg_1_load = a_rise;
                capture_reg_2_load = a_fall;
            end
            TCC_CAP_GATE:
            begin
                capture_reg_1_load = g_rise;
                capture_reg_2_load = g_fall;
            end
            default:
            begin
                capture_reg_1_load = 1'b0;
                capture_reg_2_load = 1'b0;
            end
        endcase
    end

    // Up-counter: clear on compare B when enabled, else wrap freely.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            up_counter <= '0;
        else if (hit_b && clr_en)
            up_counter <= '0;
        else if (tick)
            up_counter <= up_counter + DW'(1);
    end

    // Captures overwrite the previous value.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            capture_reg_1 <= '0;
            capture_reg_2 <= '0;
        end
        else
        begin
            if (capture_reg_1_load)
                capture_reg_1 <= up_counter;
            if (capture_reg_2_load)
                capture_reg_2 <= up_counter;
        end
    end

    // Hardware inversion sources of the two toggles.
    assign inv_a = (toggle_ctrl_reg[2] && hit_a)
                 || (toggle_ctrl_reg[3] && hit_b)
                 || (toggle_ctrl_reg[4] && capture_reg_1_load)
                 || (toggle_ctrl_reg[5] && capture_reg_2_load);
    assign inv_b = (timer_mode_reg[MODE_B_MATCH] && hit_b)
                 || (timer_mode_reg[MODE_B_CAPTURE_REG_2] && capture_reg_2_load);

    // Output toggles; reset value is fixed at zero here.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            out_toggle_a <= 1'b0;
            out_toggle_b <= 1'b0;
        end
        else
        begin
            out_toggle_a <= tgl_next(out_toggle_a, wr_tctl,
                                     reg_wdata[TCTL_A_LSB +: 2], inv_a);
            out_toggle_b <= tgl_next(out_toggle_b, wr_tctl,
                                     reg_wdata[TCTL_B_LSB +: 2], inv_b);
        end
    end

    // Control registers written by software.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            timer_mode_reg  <= MODE_RESET;
            toggle_ctrl_reg <= '0;
            compare_reg_a   <= '0;
            compare_reg_b   <= '0;
            irq_en_reg      <= '0;
        end
        else
        begin
            if (wr_mode)
                timer_mode_reg <= reg_wdata[MODE_W-1:0];
            if (wr_tctl)
                toggle_ctrl_reg <= reg_wdata[5:TCTL_EN_LSB];
            if (wr_cmp_a)
                compare_reg_a <= reg_wdata;
            if (wr_cmp_b)
                compare_reg_b <= reg_wdata;
            if (wr_en)
                irq_en_reg <= reg_wdata[ST_W-1:0];
        end
    end

    // Events that set sticky status bits.
    always_comb
    begin
        events             = '0;
        events[ST_EDGE_A]  = (capture_mode_sel == TCC_CAP_PWIDTH) ? a_fall : a_rise;
        events[ST_EDGE_B]  = b_rise;
        events[ST_MATCH_A] = hit_a;
        events[ST_MATCH_B] = hit_b;
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            status_reg <= '0;
        else if (wr_clr)
            status_reg <= (status_reg & ~reg_wdata[ST_W-1:0]) | events;
        else
            status_reg <= status_reg | events;
    end

    // Interrupt level and match pulses, all from flops.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            irq_reg     <= 1'b0;
            match_a_reg <= 1'b0;
            match_b_reg <= 1'b0;
        end
        else
        begin
            irq_reg     <= |(status_reg & irq_en_reg);
            match_a_reg <= hit_a;
            match_b_reg <= hit_b;
        end
    end

    // Read selection; unmapped and write-only words read as zero.
    always_comb
    begin
        rd_mux = '0;
        if (reg_addr == ADDR_MODE)
            rd_mux[MODE_W-1:0] = timer_mode_reg;
        else if (reg_addr == ADDR_TCTL)
            rd_mux[5:TCTL_EN_LSB] = toggle_ctrl_reg;
        else if (reg_addr == ADDR_CMP_A)
            rd_mux = compare_reg_a;
        else if (reg_addr == ADDR_CMP_B)
            rd_mux = compare_reg_b;
        else if (reg_addr == ADDR_CAPTURE_REG_1)
            rd_mux = capture_reg_1;
        else if (reg_addr == ADDR_CAPTURE_REG_2)
            rd_mux = capture_reg_2;
        else if (reg_addr == ADDR_COUNT)
            rd_mux = up_counter;
        else if (reg_addr == ADDR_STATUS)
        begin
            rd_mux[ST_W-1:0] = status_reg;
            rd_mux[ST_TGL_A] = out_toggle_a;
            rd_mux[ST_TGL_B] = out_toggle_b;
        end
        else if (reg_addr == ADDR_IRQ_EN)
            rd_mux[ST_W-1:0] = irq_en_reg;
    end

    // Read data stand for one cycle after the strobe.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            rdata_reg <= '0;
        else if (reg_rd)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= '0;
    end

    assign reg_rdata     = rdata_reg;
    assign wave_out_a    = out_toggle_a;
    assign wave_out_b    = out_toggle_b;
    assign match_pulse_a = match_a_reg;
    assign match_pulse_b = match_b_reg;
    assign irq           = irq_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_gate_cap;
        (capture_mode_sel == TCC_CAP_GATE) && g_rise && !b_fall
            |=> capture_reg_1 == $past(up_counter);
    endproperty
    a_gate_cap: assert property (p_gate_cap) else $error("gate capture 1 missed");

    property p_edge_a_fall;
        (capture_mode_sel == TCC_CAP_PWIDTH) && a_fall |=> status_reg[ST_EDGE_A];
    endproperty
    a_edge_a_fall: assert property (p_edge_a_fall) else $error("edge A irq missed");

    property p_pw_capture_reg_2;
        (capture_mode_sel == TCC_CAP_PWIDTH) && a_fall
            |=> capture_reg_2 == $past(up_counter);
    endproperty
    a_pw_capture_reg_2: assert property (p_pw_capture_reg_2) else $error("pulse width capture 2 wrong");

    property p_td_a;
        (capture_mode_sel == TCC_CAP_TDIFF) && a_rise
            |=> capture_reg_1 == $past(up_counter) && status_reg[ST_EDGE_A];
    endproperty
    a_td_a: assert property (p_td_a) else $error("time diff A wrong");

    property p_td_b;
        (capture_mode_sel == TCC_CAP_TDIFF) && b_rise
            |=> capture_reg_2 == $past(up_counter) && status_reg[ST_EDGE_B];
    endproperty
    a_td_b: assert property (p_td_b) else $error("time diff B wrong");

    property p_cap_inv;
        capture_reg_1_load && toggle_ctrl_reg[4] && !wr_tctl |=> out_toggle_a != $past(out_toggle_a);
    endproperty
    a_cap_inv: assert property (p_cap_inv) else $error("toggle A not inverted");

    property p_no_inv;
        !inv_a && !wr_tctl |=> $stable(out_toggle_a);
    endproperty
    a_no_inv: assert property (p_no_inv) else $error("toggle A changed");

    property p_clear_b;
        hit_b && clr_en |=> up_counter == '0 ##1 up_counter <= DW'(1);
    endproperty
    a_clear_b: assert property (p_clear_b) else $error("counter not cleared");

    property p_wrap;
        tick && up_counter == '1 && !(hit_b && clr_en) |=> up_counter == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    // A write of enable in the hit cycle may legally withdraw the level; a clear there cannot.
    property p_match_irq;
        hit_a && irq_en_reg[ST_MATCH_A] && !wr_en ##1 !wr_en && !wr_clr
            |-> match_pulse_a ##1 irq;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match A no irq");
endmodule

/* pkg/tcc_pkg.sv */
// Purpose: Shared constants and types of the 16-bit capture and compare timer.
// Assumes: One 10 MHz clock; 16-bit register data on a plain strobe port.
// Notes:   Tap periods are derived from the full count cycle times.
package tcc_pkg;
    localparam int DW = 16;
    localparam int AW = 8;

    // Register byte addresses.
    localparam logic [AW-1:0] ADDR_MODE    = 8'h00;
    localparam logic [AW-1:0] ADDR_TCTL    = 8'h04;
    localparam logic [AW-1:0] ADDR_CMP_A   = 8'h08;
    localparam logic [AW-1:0] ADDR_CMP_B   = 8'h0C;
    localparam logic [AW-1:0] ADDR_CAPTURE_REG_1    = 8'h10;
    localparam logic [AW-1:0] ADDR_CAPTURE_REG_2    = 8'h14;
    localparam logic [AW-1:0] ADDR_COUNT   = 8'h18;
    localparam logic [AW-1:0] ADDR_STATUS  = 8'h1C;
    localparam logic [AW-1:0] ADDR_IRQ_CLR = 8'h20;
    localparam logic [AW-1:0] ADDR_IRQ_EN  = 8'h24;

    // Mode register fields.
    localparam int MODE_CLK_LSB = 0;
    localparam int MODE_CLR_EN  = 2;
    localparam int MODE_CAP_LSB = 3;
    localparam int MODE_RUN     = 5;
    localparam int MODE_B_MATCH = 6;
    localparam int MODE_B_CAPTURE_REG_2  = 7;
    localparam int MODE_W       = 8;
    localparam logic [MODE_W-1:0] MODE_RESET = 8'h04;

    // Toggle control fields; bits 1:0 and 7:6 are write-only actions.
    localparam int TCTL_A_LSB   = 0;
    localparam int TCTL_EN_LSB  = 2;
    localparam int TCTL_B_LSB   = 6;
    localparam logic [1:0] TGL_INVERT = 2'h0;
    localparam logic [1:0] TGL_CLEAR  = 2'h1;
    localparam logic [1:0] TGL_SET    = 2'h2;

    // Status bit positions; those below ST_W are shared by status, clear and enable.
    localparam int ST_EDGE_A  = 0;
    localparam int ST_EDGE_B  = 1;
    localparam int ST_MATCH_A = 2;
    localparam int ST_MATCH_B = 3;
    localparam int ST_W       = 4;
    localparam int ST_TGL_A   = 4;
    localparam int ST_TGL_B   = 5;

    typedef enum logic [1:0] {
        TCC_CLK_EVENT_A = 2'h0,
        TCC_CLK_TAP1    = 2'h1,
        TCC_CLK_TAP4    = 2'h2,
        TCC_CLK_TAP16   = 2'h3
    } tcc_clk_sel_type;

    typedef enum logic [1:0] {
        TCC_CAP_OFF    = 2'h0,
        TCC_CAP_TDIFF  = 2'h1,
        TCC_CAP_PWIDTH = 2'h2,
        TCC_CAP_GATE   = 2'h3
    } tcc_cap_mode_type;

    // Timing: full 16-bit cycle per tap, counted in clock cycles per tick.
    localparam real CLK_PERIOD_NS   = 100.0;
    localparam real CYCLE_TAP1_MS   = 26.214;
    localparam real CYCLE_TAP4_MS   = 104.856;
    localparam real CYCLE_TAP16_MS  = 419.424;
    localparam real COUNT_STATES    = 65536.0;
    localparam int  TAP1_CYC  = $rtoi(CYCLE_TAP1_MS * 1.0e6 / COUNT_STATES / CLK_PERIOD_NS + 0.5);
    localparam int  TAP4_CYC  = $rtoi(CYCLE_TAP4_MS * 1.0e6 / COUNT_STATES / CLK_PERIOD_NS + 0.5);
    localparam int  TAP16_CYC = $rtoi(CYCLE_TAP16_MS * 1.0e6 / COUNT_STATES / CLK_PERIOD_NS + 0.5);
    localparam int  PRE_W     = 7;
endpackage

/* hw/tcc_edge_sync.sv */
// Purpose: Two-stage synchroniser with rise and fall pulses.
// Assumes: Input may change at any time relative to mclk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module tcc_edge_sync (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Chain of three flops; edges are seen between the last two.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // One pulse per settled edge.
    assign rise = sync_reg & ~last_reg;
    assign fall = ~sync_reg & last_reg;
endmodule

/* hw/tcc_prescaler.sv */
// Purpose: Prescaler giving one-cycle enable pulses at three tap rates.
// Assumes: Tap periods divide the longest one.
// Notes:   Held at zero while not running so taps restart in phase.
`timescale 1ns/100ps
module tcc_prescaler import tcc_pkg::*; (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic run,
    output logic      tap1,
    output logic      tap4,
    output logic      tap16
);
    logic [PRE_W-1:0] cnt_reg;

    // Free count modulo the slowest tap period.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            cnt_reg <= '0;
        else if (!run || cnt_reg == PRE_W'(TAP16_CYC - 1))
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + PRE_W'(1);
    end

    // A tap fires on the last cycle of its period.
    assign tap1  = run && (int'(cnt_reg) % TAP1_CYC) == TAP1_CYC - 1;
    assign tap4  = run && (int'(cnt_reg) % TAP4_CYC) == TAP4_CYC - 1;
    assign tap16 = run && (int'(cnt_reg) % TAP16_CYC) == TAP16_CYC - 1;
endmodule

/* verif/tcc_pins_model.sv */
// Purpose: Model of the event pins and the gate toggle beside the timer.
// Assumes: The bench holds each requested level for several clocks.
// Notes:   Pins change just after a rising edge, as real logic would.
`timescale 1ns/100ps
module tcc_pins_model (
    input  wire logic       mclk,
    input  wire logic [2:0] lvl_req,
    output logic            event_in_a,
    output logic            event_in_b,
    output logic            ext_gate_toggle
);
    // Pins start low and follow the requested levels one clock later.
    initial {ext_gate_toggle, event_in_b, event_in_a} = 3'h0;
    always @(posedge mclk)
    begin
        {ext_gate_toggle, event_in_b, event_in_a} <= lvl_req;
    end
endmodule

/* verif/tcc_top_bench.sv */
// Purpose: Self-checking bench of the capture and compare timer.
// Assumes: Tap one gives a tick every TAP1_CYC clocks.
// Notes:   Captures are taken with the counter stopped, so values are known.
`timescale 1ns/100ps
module tcc_top_bench import tcc_pkg::*;;
    logic mclk, reset, reg_wr, reg_rd, irq;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata, reg_rdata, v, v2, c;
    logic wave_out_a, wave_out_b, match_pulse_a, match_pulse_b;
    logic ev_a, ev_b, gate;
    logic [2:0] lvl;
    logic [1:0] w0;
    int err_total, n_checks, n;
    localparam logic [15:0] ROWS [5][2] = '{'{16'h0081, 16'h0002}, '{16'h0042, 16'h0001},
        '{16'h0000, 16'h0002}, '{16'h00C3, 16'h0002}, '{16'h0040, 16'h0001}};

    tcc_top tcc_top_inst (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .event_in_a(ev_a), .event_in_b(ev_b), .ext_gate_toggle(gate),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .match_pulse_a(match_pulse_a),
        .match_pulse_b(match_pulse_b), .irq(irq));
    tcc_pins_model tcc_pins_model_inst (.mclk(mclk), .lvl_req(lvl), .event_in_a(ev_a),
        .event_in_b(ev_b), .ext_gate_toggle(gate));

    // Clock of 100 ns period.
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One write strobe, then an idle edge so the strobe never changes twice in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #10;
        d = reg_rdata;
        @(posedge mclk);
    endtask

    // Compares irq and both waves under a mask once they have settled.
    task automatic look(input logic [15:0] exp, input logic [15:0] m);
        @(posedge mclk);
        #10;
        chk({13'h0, irq, wave_out_b, wave_out_a} & m, exp);
        @(posedge mclk);
    endtask

    task automatic grab(output logic [1:0] w);
        #10;
        w = {wave_out_b, wave_out_a};
        @(posedge mclk);
    endtask

    task automatic pin(input int b, input logic lv);
        lvl[b] <= lv;
        repeat (8) @(posedge mclk);
    endtask

    // Runs the counter briefly, stops it and reads where it stopped.
    task automatic snap(input logic [15:0] m, output logic [15:0] q);
        wr(ADDR_MODE, m | 16'h0020);
        repeat (20) @(posedge mclk);
        wr(ADDR_MODE, m);
        repeat (2) @(posedge mclk);
        rd(ADDR_COUNT, q);
    endtask

    // Counts clocks until the next compare pulse, B when sel is set, else A.
    task automatic wait_mp(input logic sel, output int k);
        k = 0;
        do
        begin
            @(posedge mclk);
            #10;
            k++;
        end
        while ((sel ? match_pulse_b : match_pulse_a) !== 1'b1 && k < 500);
        chk({14'h0, match_pulse_b, match_pulse_a}, sel ? 16'h0002 : 16'h0001);
        @(posedge mclk);
    endtask

    // Cuts a hang short.
    initial
    begin
        #3000000;
        err_total++;
        print_verdict();
    end

    // Main sequence.
    initial
    begin
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata, lvl} = '0;
        reset = 1'b1;
        err_total = 0;
        n_checks = 0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        for (int k = 0; k < 5; k++)
        begin
            wr(ADDR_TCTL, ROWS[k][0]);
            look(ROWS[k][1], 16'h0003);
        end
        // Free run on tap one, clear on compare B, phase output.
        wr(ADDR_CMP_A, 16'h0003);
        wr(ADDR_CMP_B, 16'h0009);
        wr(ADDR_IRQ_EN, 16'h000C);
        wr(ADDR_TCTL, 16'h00C7);
        wr(ADDR_MODE, 16'h0065);
        wait_mp(1'b1, n);
        grab(w0);
        wait_mp(1'b1, n);
        // The grab and the closing edge of the first wait are two uncounted edges.
        chk(16'(n + 2), 16'(10 * TAP1_CYC));
        look({14'h0, ~w0} | 16'h0004, 16'h0007);
        rd(ADDR_STATUS, v);
        chk(v & 16'h000C, 16'h000C);
        wr(ADDR_IRQ_EN, 16'h0000);
        look(16'h0000, 16'h0004);
        wr(ADDR_IRQ_EN, 16'h0008);
        look(16'h0004, 16'h0004);
        wait_mp(1'b0, n);
        wr(ADDR_TCTL, 16'h00C3);
        wr(ADDR_MODE, 16'h0025);
        grab(w0);
        repeat (45) @(posedge mclk);
        look({14'h0, w0}, 16'h0003);
        wr(ADDR_MODE, 16'h0005);
        wr(ADDR_IRQ_CLR, 16'h000F);
        look(16'h0000, 16'h0004);
        // Event input A clocks the counter.
        wr(ADDR_MODE, 16'h0020);
        rd(ADDR_COUNT, v);
        repeat (5)
        begin
            pin(0, 1'b1);
            pin(0, 1'b0);
        end
        rd(ADDR_COUNT, v2);
        chk(v2, v + 16'h0005);
        // Time difference with toggle A inverting on capture 1.
        wr(ADDR_TCTL, 16'h00D3);
        snap(16'h0009, v);
        grab(w0);
        pin(0, 1'b1);
        rd(ADDR_CAPTURE_REG_1, c);
        chk(c, v);
        look({15'h0, ~w0[0]}, 16'h0001);
        pin(0, 1'b0);
        pin(1, 1'b1);
        rd(ADDR_CAPTURE_REG_2, c);
        chk(c, v);
        rd(ADDR_STATUS, c);
        chk(c & 16'h0003, 16'h0003);
        pin(1, 1'b0);
        snap(16'h0009, v2);
        pin(0, 1'b1);
        rd(ADDR_CAPTURE_REG_1, c);
        chk(c, v2);
        pin(0, 1'b0);
        // Pulse width: interrupt A only on the falling edge.
        wr(ADDR_IRQ_CLR, 16'h000F);
        snap(16'h0011, v);
        pin(0, 1'b1);
        rd(ADDR_STATUS, c);
        chk(c & 16'h0001, 16'h0000);
        rd(ADDR_CAPTURE_REG_1, c);
        chk(c, v);
        snap(16'h0011, v2);
        pin(0, 1'b0);
        rd(ADDR_CAPTURE_REG_2, c);
        chk(c, v2);
        rd(ADDR_STATUS, c);
        chk(c & 16'h0001, 16'h0001);
        // Gate toggle edges load both captures.
        snap(16'h0019, v);
        pin(2, 1'b1);
        rd(ADDR_CAPTURE_REG_1, c);
        chk(c, v);
        snap(16'h0019, v2);
        pin(2, 1'b0);
        rd(ADDR_CAPTURE_REG_2, c);
        chk(c, v2);
        // Second reset in mid-run restores mode and clears outputs.
        reset <= 1'b1;
        look(16'h0000, 16'h0007);
        reset <= 1'b0;
        @(posedge mclk);
        rd(ADDR_MODE, c);
        chk(c, 16'(MODE_RESET));
        rd(8'h30, c);
        chk(c, 16'h0000);
        print_verdict();
    end
endmodule
